// file: design/bif_select_pkg.sv
// package for the binary input function select block: function codes, carriers, timing.
// assumes a 250 MHz control clock.
`default_nettype none
package func_select_pkg;
    localparam int          NUM_TERMINALS       = 8;
    localparam int          FUNC_W              = 6;
    localparam int          SPEED_W             = 16;
    localparam int          SYS_CLK_HZ          = 250_000_000;
    localparam int          CONFLICT_TIME_MS    = 500;
    localparam int          SWITCH_TIME_MS      = 25;
    localparam int          CONFLICT_CYCLES     = SYS_CLK_HZ / 1000 * CONFLICT_TIME_MS;
    localparam int          SWITCH_CYCLES       = SYS_CLK_HZ / 1000 * SWITCH_TIME_MS;
    localparam logic [3:0]  PEER_PROTOCOL_CODE  = 4'h4;
    localparam logic [7:0]  PEER_BAUD_CODE      = 8'h0a;
    localparam logic [7:0]  PEER_TORQUE_SOURCE  = 8'h14;
    localparam logic [7:0]  PEER_TX_WORD0_CODE  = 8'h93;
    localparam logic [1:0]  RAMP_SET_RESET      = 2'h0;
    localparam logic [1:0]  PARAM_SET_RESET     = 2'h0;

    // function codes a terminal may be assigned
    localparam logic [FUNC_W-1:0] FN_POT_AUTO      = 6'h19;
    localparam logic [FUNC_W-1:0] FN_POT_REVERSE   = 6'h1c;
    localparam logic [FUNC_W-1:0] FN_POT_POSITIVE  = 6'h1d;
    localparam logic [FUNC_W-1:0] FN_POT_NEGATIVE  = 6'h1e;
    localparam logic [FUNC_W-1:0] FN_RAMP_SET2     = 6'h1f;
    localparam logic [FUNC_W-1:0] FN_RAMP_SET3     = 6'h20;
    localparam logic [FUNC_W-1:0] FN_PARAM_SET2    = 6'h21;
    localparam logic [FUNC_W-1:0] FN_PARAM_SET3    = 6'h22;
    localparam logic [FUNC_W-1:0] FN_PARAM_SET4    = 6'h23;
    localparam logic [FUNC_W-1:0] FN_TECH_DROOP    = 6'h24;
    localparam logic [FUNC_W-1:0] FN_SPEED_DROOP   = 6'h25;
    localparam logic [FUNC_W-1:0] FN_P_ONLY        = 6'h26;
    localparam logic [FUNC_W-1:0] FN_INERTIA_COMP  = 6'h27;
    localparam logic [FUNC_W-1:0] FN_SPEED_FB_REV  = 6'h28;
    localparam logic [FUNC_W-1:0] FN_ROLE_SLAVE    = 6'h29;
    localparam logic [FUNC_W-1:0] FN_TORQUE_SET2   = 6'h2a;

    typedef struct packed {
        logic [1:0]  ramp_set_select_param;
        logic        tech_droop_param;
        logic        speed_droop_param;
        logic [7:0]  inertia_comp_enable_param;
        logic [SPEED_W-1:0] p_only_speed_threshold;
        logic [SPEED_W-1:0] torque_limit_speed_threshold;
        logic [7:0]  slave_torque_source_param;
        logic [3:0]  bus_protocol_select_param;
        logic [7:0]  baud_code_param;
        logic [7:0]  peer_tx_word0_param;
    } drive_params_type;

    typedef struct packed {
        logic        slave_mode;
        logic        speed_ctrl_disable;
        logic        peer_tx_enable;
        logic        peer_rx_enable;
        logic        peer_bus_ready;
        logic        torque_from_peer;
        logic        torque_is_tx_word0;
    } role_status_type;

    typedef enum logic [1:0] {
        PSET_IDLE     = 2'b00,
        PSET_SWITCH   = 2'b01,
        PSET_CONFLICT = 2'b11
    } pset_state_type;
endpackage : func_select_pkg
`default_nettype wire

// file: design/drive_binary_input_function_select.sv
// binary input function decoder: terminals with assigned functions to selection signals.
// assumes terminal levels are asynchronous contacts; the function map and parameters are
// quasi-static and come from the drive's parameter store on sys_clk_i.
//
// Summary of operation
// - reverse terminal inverts pot reference in manual
// - push-button assignment disables pot reverse function
// - positive push-button forces positive pot sign
// - negative push-button forces negative pot sign
// - ramp set two terminal overrides parameter
// - ramp set three overrides; else set one
// - both ramp sets selected trips conflict fault
// - parameter set terminal activates that set
// - multiple sets over half second: fault, hold
// - new parameter set active within 25 ms
// - tech droop: any terminal, else parameter
// - speed droop: all terminals, else parameter
// - P-only when all energized and speed low
// - inertia comp when all energized, param one
// - any speed-reversal terminal inverts speed feedback
// - slave role: external torque, speed loop off
// - master transmits only; slave receives only
// - peer protocol, baud code ten, word zero torque
// - torque set two: any terminal and fast
// - manual: raise/lower drive pot; auto: source
`default_nettype none
module drive_binary_input_function_select
    import func_select_pkg::*;
#(
    parameter int N_TERM         = NUM_TERMINALS,
    parameter int CONFLICT_COUNT = CONFLICT_CYCLES,
    parameter int SWITCH_COUNT   = SWITCH_CYCLES
) (
    // clock and reset
    input  wire logic                       sys_clk_i,
    input  wire logic                       resetn_i,
    // terminals and their function assignment
    input  wire logic [N_TERM-1:0]          terminal_i,
    input  wire logic [N_TERM*FUNC_W-1:0]   binary_input_function_i,
    // drive parameters and measurements
    input  wire drive_params_type           params_i,
    input  wire logic signed [SPEED_W-1:0]  speed_i,
    input  wire logic                       self_tune_active_i,
    // potentiometer commands
    input  wire logic                       pot_raise_i,
    input  wire logic                       pot_lower_i,
    // selections
    output logic                            pot_manual_o,
    output logic                            pot_raise_o,
    output logic                            pot_lower_o,
    output logic                            pot_negative_o,
    output logic [1:0]                      ramp_set_o,
    output logic [1:0]                      param_set_o,
    output logic                            param_set_busy_o,
    output logic                            config_conflict_fault_o,
    output logic                            tech_droop_o,
    output logic                            speed_droop_o,
    output logic                            p_only_o,
    output logic                            inertia_comp_o,
    output logic                            speed_fb_invert_o,
    output logic                            torque_limit_set2_o,
    output role_status_type                 role_o
);
    localparam int CNT_W = $clog2(CONFLICT_COUNT + 1);
    localparam int FN_COUNT = 16;
    localparam logic [FUNC_W-1:0] FN_LIST [FN_COUNT] = '{
        FN_POT_AUTO, FN_POT_REVERSE, FN_POT_POSITIVE, FN_POT_NEGATIVE,
        FN_RAMP_SET2, FN_RAMP_SET3, FN_PARAM_SET2, FN_PARAM_SET3,
        FN_PARAM_SET4, FN_TECH_DROOP, FN_SPEED_DROOP, FN_P_ONLY,
        FN_INERTIA_COMP, FN_SPEED_FB_REV, FN_ROLE_SLAVE, FN_TORQUE_SET2};

    logic [N_TERM-1:0]   sync_stage;
    logic [N_TERM-1:0]   term_sync;
    logic [FN_COUNT-1:0] fn_assigned;
    logic [FN_COUNT-1:0] fn_any;
    logic [FN_COUNT-1:0] fn_all;

    // contacts bounce and are asynchronous; two stages before any decode
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            sync_stage <= '0;
            term_sync  <= '0;
        end else begin
            sync_stage <= terminal_i;
            term_sync  <= sync_stage;
        end
    end

    generate
        for (genvar f = 0; f < FN_COUNT; f++) begin : g_fn
            logic [N_TERM-1:0] hit;
            for (genvar t = 0; t < N_TERM; t++) begin : g_term
                assign hit[t] = (binary_input_function_i[t*FUNC_W +: FUNC_W] == FN_LIST[f]);
            end
            assign fn_assigned[f] = |hit;
            assign fn_any[f]      = |(hit & term_sync);
            assign fn_all[f]      = (|hit) && ((hit & ~term_sync) == '0);
        end
    endgenerate

    wire pot_manual  = !fn_any[0];
    wire pb_assigned = fn_assigned[2] || fn_assigned[3];
    wire ramp2       = fn_any[4];
    wire ramp3       = fn_any[5];
    wire [2:0] pset_req = {fn_any[8], fn_any[7], fn_any[6]};
    wire pset_multi  = (pset_req & (pset_req - 3'h1)) != 3'h0;
    logic [1:0] pset_target;

    always_comb begin
        pset_target = 2'h0;
        if (pset_req[0]) pset_target = 2'h1;
        if (pset_req[1]) pset_target = 2'h2;
        if (pset_req[2]) pset_target = 2'h3;
    end

    // potentiometer mode and polarity
    logic rev_level_q;
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            pot_manual_o   <= 1'b1;
            pot_raise_o    <= 1'b0;
            pot_lower_o    <= 1'b0;
            pot_negative_o <= 1'b0;
            rev_level_q    <= 1'b0;
        end else begin
            pot_manual_o <= pot_manual;
            // lower wins when both are pressed
            pot_raise_o  <= pot_manual && pot_raise_i && !pot_lower_i;
            pot_lower_o  <= pot_manual && pot_lower_i;
            rev_level_q  <= fn_any[1];
            if (pot_manual) begin
                if (pb_assigned) begin
                    if (fn_any[3]) begin
                        pot_negative_o <= 1'b1;
                    end else if (fn_any[2]) begin
                        pot_negative_o <= 1'b0;
                    end
                end else if (fn_any[1] != rev_level_q) begin
                    // ramping to the inverted value is the pot integrator's job
                    pot_negative_o <= !pot_negative_o;
                end
            end
        end
    end

    // ramp set choice and its conflict
    logic ramp_conflict;
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            ramp_set_o    <= RAMP_SET_RESET;
            ramp_conflict <= 1'b0;
        end else begin
            ramp_conflict <= ramp2 && ramp3;
            if (ramp2 && !ramp3) begin
                ramp_set_o <= 2'h1;
            end else if (ramp3 && !ramp2) begin
                ramp_set_o <= 2'h2;
            end else if (!ramp2 && !ramp3) begin
                ramp_set_o <= (fn_assigned[4] || fn_assigned[5]) ? 2'h0
                                                                 : params_i.ramp_set_select_param;
            end
        end
    end

    // parameter set switching
    pset_state_type   pset_state;
    logic [CNT_W-1:0] conflict_cnt;
    logic [CNT_W-1:0] switch_cnt;
    logic             pset_conflict;
    logic [1:0]       pending_set;

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            conflict_cnt  <= '0;
            pset_conflict <= 1'b0;
        end else if (!pset_multi) begin
            conflict_cnt  <= '0;
            pset_conflict <= 1'b0;
        end else if (conflict_cnt >= CNT_W'(CONFLICT_COUNT)) begin
            pset_conflict <= 1'b1;
        end else begin
            conflict_cnt <= conflict_cnt + CNT_W'(1);
        end
    end

    // a change requested during self-tuning is held off until tuning ends
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            pset_state  <= PSET_IDLE;
            param_set_o <= PARAM_SET_RESET;
            pending_set <= PARAM_SET_RESET;
            switch_cnt  <= '0;
        end else begin
            case (pset_state)
                PSET_IDLE: begin
                    if (pset_multi) begin
                        pset_state <= PSET_CONFLICT;
                    end else if (pset_target != param_set_o && !self_tune_active_i) begin
                        pending_set <= pset_target;
                        switch_cnt  <= '0;
                        pset_state  <= PSET_SWITCH;
                    end
                end
                PSET_SWITCH: begin
                    // set stays valid while the new one is copied in, drive keeps running
                    if (switch_cnt >= CNT_W'(SWITCH_COUNT - 1)) begin
                        param_set_o <= pending_set;
                        pset_state  <= PSET_IDLE;
                    end else begin
                        switch_cnt <= switch_cnt + CNT_W'(1);
                    end
                end
                PSET_CONFLICT: begin
                    if (!pset_multi) begin
                        pset_state <= PSET_IDLE;
                    end
                end
                default: pset_state <= PSET_IDLE;
            endcase
        end
    end

    assign param_set_busy_o = (pset_state == PSET_SWITCH);

    // fault latches until reset; a new conflict is never masked
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            config_conflict_fault_o <= 1'b0;
        end else if (ramp_conflict || pset_conflict) begin
            config_conflict_fault_o <= 1'b1;
        end
    end

    // controller structure selections
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            tech_droop_o        <= 1'b0;
            speed_droop_o       <= 1'b0;
            p_only_o            <= 1'b0;
            inertia_comp_o      <= 1'b0;
            speed_fb_invert_o   <= 1'b0;
            torque_limit_set2_o <= 1'b0;
        end else begin
            tech_droop_o  <= fn_assigned[9] ? fn_any[9] : params_i.tech_droop_param;
            speed_droop_o <= fn_assigned[10] ? fn_all[10] : params_i.speed_droop_param;
            p_only_o      <= fn_all[11] && (speed_i < $signed(params_i.p_only_speed_threshold));
            inertia_comp_o <= fn_all[12] && (params_i.inertia_comp_enable_param == 8'h01);
            speed_fb_invert_o <= fn_any[13];
            torque_limit_set2_o <= fn_any[15] &&
                (speed_i > $signed(params_i.torque_limit_speed_threshold));
        end
    end

    // master/slave role and peer bus gating
    wire peer_cfg = (params_i.bus_protocol_select_param == PEER_PROTOCOL_CODE) &&
                    (params_i.baud_code_param == PEER_BAUD_CODE);
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            role_o <= '0;
        end else begin
            role_o.slave_mode         <= fn_any[14];
            role_o.speed_ctrl_disable <= fn_any[14];
            // handover overlap is prevented by the controller's ordering
            role_o.peer_tx_enable     <= peer_cfg && !fn_any[14];
            role_o.peer_rx_enable     <= peer_cfg && fn_any[14];
            role_o.peer_bus_ready     <= peer_cfg;
            role_o.torque_from_peer   <= fn_any[14] &&
                (params_i.slave_torque_source_param == PEER_TORQUE_SOURCE);
            role_o.torque_is_tx_word0 <= params_i.peer_tx_word0_param == PEER_TX_WORD0_CODE;
        end
    end

    conflict_fault_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (ramp2 && ramp3) |-> ##2 config_conflict_fault_o)
        else $error("ramp conflict did not trip fault");
    pset_hold_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (pset_state == PSET_CONFLICT) |=> $stable(param_set_o))
        else $error("parameter set changed during conflict");
    pset_switch_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        $rose(param_set_busy_o) |-> ##[1:2] (switch_cnt != '0 || SWITCH_COUNT <= 1))
        else $error("parameter switch timer stuck");
    role_gate_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        !(role_o.peer_tx_enable && role_o.peer_rx_enable))
        else $error("transmitter and receiver both enabled");
    slave_mode_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        fn_any[14] |=> role_o.slave_mode && role_o.speed_ctrl_disable)
        else $error("slave mode not entered");
    fb_invert_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        fn_any[13] |=> speed_fb_invert_o)
        else $error("speed feedback not inverted");
    pot_force_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (pot_manual && fn_any[3]) |=> pot_negative_o)
        else $error("pot sign not forced negative");
    droop_all_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (fn_assigned[10] && !fn_all[10]) |=> !speed_droop_o)
        else $error("speed droop on with terminal open");
    ramp_sel_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (ramp3 && !ramp2) |=> ramp_set_o == 2'h2)
        else $error("ramp set three not chosen");
endmodule : drive_binary_input_function_select
`default_nettype wire

// file: tb/bif_control_panel.sv
// control panel model: drives the contact levels seen at the terminals.
// assumes it gets the same function map as the decoder.
`default_nettype none
module terminal_panel
    import func_select_pkg::*;
(
    // clock and commands
    input  wire logic                   sys_clk_i,
    input  wire logic                   self_tune_active_i,
    input  wire logic [8*FUNC_W-1:0]    binary_input_function_i,
    input  wire logic [7:0]             request_i,
    // contact levels
    output logic      [7:0]             terminal_o
);
    timeunit 1ns;
    timeprecision 1ps;
    function automatic logic is_pset(input int t);
        logic [FUNC_W-1:0] fn;
        fn = binary_input_function_i[t*FUNC_W+:FUNC_W];
        return fn inside {FN_PARAM_SET2, FN_PARAM_SET3, FN_PARAM_SET4};
    endfunction : is_pset
    // set contacts stay put during self-tuning, a changed set would corrupt the run
    always @(negedge sys_clk_i) begin
        for (int t = 0; t < 8; t++) begin
            if (!(self_tune_active_i && is_pset(t))) begin
                terminal_o[t] <= request_i[t];
            end
        end
    end
endmodule : terminal_panel
`default_nettype wire

// file: tb/test_drive_binary_input_function_select.sv
// testbench for the binary input function decoder.
// assumes short conflict and switch counts; inputs change on the falling edge.
`default_nettype none
module test_drive_binary_input_function_select
    import func_select_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 0, resetn_i = 0, self_tune_active_i = 0, pot_raise_i = 0, pot_lower_i = 0;
    logic [7:0] request = 8'h00;
    logic [7:0] terminal_i;
    logic [47:0] binary_input_function_i = 48'h0;
    drive_params_type params_i;
    logic signed [15:0] speed_i = 16'sh0080;
    logic pot_manual_o, pot_raise_o, pot_lower_o, pot_negative_o, param_set_busy_o;
    logic config_conflict_fault_o, tech_droop_o, speed_droop_o, p_only_o, inertia_comp_o;
    logic speed_fb_invert_o, torque_limit_set2_o;
    logic [1:0] ramp_set_o, param_set_o;
    role_status_type role_o;
    int failures = 0, tests_run = 0, cyc = 0;

    always #2 sys_clk_i = ~sys_clk_i;

    drive_binary_input_function_select #(.CONFLICT_COUNT(20), .SWITCH_COUNT(5))
    drive_binary_input_function_select_i (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .terminal_i(terminal_i),
        .binary_input_function_i(binary_input_function_i), .params_i(params_i),
        .speed_i(speed_i), .self_tune_active_i(self_tune_active_i),
        .pot_raise_i(pot_raise_i), .pot_lower_i(pot_lower_i), .pot_manual_o(pot_manual_o),
        .pot_raise_o(pot_raise_o), .pot_lower_o(pot_lower_o), .pot_negative_o(pot_negative_o),
        .ramp_set_o(ramp_set_o), .param_set_o(param_set_o), .param_set_busy_o(param_set_busy_o),
        .config_conflict_fault_o(config_conflict_fault_o), .tech_droop_o(tech_droop_o),
        .speed_droop_o(speed_droop_o), .p_only_o(p_only_o), .inertia_comp_o(inertia_comp_o),
        .speed_fb_invert_o(speed_fb_invert_o), .torque_limit_set2_o(torque_limit_set2_o),
        .role_o(role_o));

    terminal_panel terminal_panel_i (
        .sys_clk_i(sys_clk_i), .self_tune_active_i(self_tune_active_i),
        .binary_input_function_i(binary_input_function_i), .request_i(request),
        .terminal_o(terminal_i));

    task automatic test_done();
        if (failures == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    // whole run needs well under a thousand cycles
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            test_done();
        end
    end

    task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // panel adds one cycle, decoder answers three edges later
    // non-blocking so the panel never races the bench on the same falling edge
    task automatic set_term(input logic [7:0] v);
        request <= v;
        repeat (6) @(negedge sys_clk_i);
    endtask : set_term

    task automatic map(input int t, input logic [5:0] code);
        binary_input_function_i[t*6+:6] = code;
    endtask : map

    task automatic do_reset();
        resetn_i = 0;
        binary_input_function_i = 48'h0;
        set_term(8'h00);
        repeat (14) @(negedge sys_clk_i);
        resetn_i = 1;
        @(negedge sys_clk_i);
    endtask : do_reset

    task automatic t_reset();
        chk("manual", 2'h1, {1'b0, pot_manual_o});
        chk("ramp", 2'h1, ramp_set_o);
        chk("pset", 2'h0, param_set_o);
        chk("fault", 2'h0, {1'b0, config_conflict_fault_o});
    endtask : t_reset

    task automatic t_pot();
        map(0, FN_POT_REVERSE);
        set_term(8'h01);
        chk("neg", 2'h1, {1'b0, pot_negative_o});
        set_term(8'h00);
        chk("neg", 2'h0, {1'b0, pot_negative_o});
        map(1, FN_POT_NEGATIVE);
        set_term(8'h01);
        chk("neg", 2'h0, {1'b0, pot_negative_o});
        set_term(8'h02);
        chk("neg", 2'h1, {1'b0, pot_negative_o});
        set_term(8'h00);
        chk("neg", 2'h1, {1'b0, pot_negative_o});
        map(2, FN_POT_POSITIVE);
        set_term(8'h04);
        chk("neg", 2'h0, {1'b0, pot_negative_o});
        pot_raise_i = 1;
        set_term(8'h00);
        chk("neg", 2'h0, {1'b0, pot_negative_o});
        chk("raise", 2'h1, {1'b0, pot_raise_o});
        pot_lower_i = 1;
        set_term(8'h00);
        chk("lower", 2'h1, {pot_raise_o, pot_lower_o});
        map(3, FN_POT_AUTO);
        set_term(8'h0a);
        chk("auto", 2'h0, {pot_manual_o, pot_lower_o});
        chk("neg", 2'h0, {1'b0, pot_negative_o});
        pot_raise_i = 0;
        pot_lower_i = 0;
        do_reset();
    endtask : t_pot

    task automatic t_ramp();
        map(0, FN_RAMP_SET2);
        map(1, FN_RAMP_SET3);
        set_term(8'h00);
        chk("ramp", 2'h0, ramp_set_o);
        set_term(8'h01);
        chk("ramp", 2'h1, ramp_set_o);
        set_term(8'h02);
        chk("ramp", 2'h2, ramp_set_o);
        set_term(8'h03);
        chk("fault", 2'h1, {1'b0, config_conflict_fault_o});
        do_reset();
    endtask : t_ramp

    task automatic t_pset();
        map(2, FN_PARAM_SET2);
        map(3, FN_PARAM_SET3);
        map(4, FN_PARAM_SET4);
        set_term(8'h08);
        chk("busy", 2'h1, {1'b0, param_set_busy_o});
        repeat (4) @(negedge sys_clk_i);
        chk("pset", 2'h2, param_set_o);
        self_tune_active_i = 1;
        set_term(8'h10);
        repeat (4) @(negedge sys_clk_i);
        chk("pset", 2'h2, param_set_o);
        self_tune_active_i = 0;
        set_term(8'h10);
        repeat (4) @(negedge sys_clk_i);
        chk("pset", 2'h3, param_set_o);
        set_term(8'h14);
        chk("fault", 2'h0, {1'b0, config_conflict_fault_o});
        repeat (24) @(negedge sys_clk_i);
        chk("fault", 2'h1, {1'b0, config_conflict_fault_o});
        chk("pset", 2'h3, param_set_o);
        do_reset();
    endtask : t_pset

    task automatic t_droop();
        chk("droop", 2'h2, {tech_droop_o, speed_droop_o});
        map(5, FN_TECH_DROOP);
        map(6, FN_SPEED_DROOP);
        map(7, FN_SPEED_DROOP);
        set_term(8'h00);
        chk("droop", 2'h0, {tech_droop_o, speed_droop_o});
        set_term(8'h60);
        chk("droop", 2'h2, {tech_droop_o, speed_droop_o});
        set_term(8'hc0);
        chk("droop", 2'h1, {tech_droop_o, speed_droop_o});
        do_reset();
    endtask : t_droop

    task automatic t_misc();
        map(0, FN_P_ONLY);
        map(1, FN_P_ONLY);
        map(2, FN_INERTIA_COMP);
        map(3, FN_SPEED_FB_REV);
        map(4, FN_TORQUE_SET2);
        set_term(8'h1d);
        chk("ponly", 2'h1, {p_only_o, inertia_comp_o});
        chk("fbinv", 2'h1, {torque_limit_set2_o, speed_fb_invert_o});
        set_term(8'h1f);
        chk("ponly", 2'h3, {p_only_o, inertia_comp_o});
        speed_i = 16'sh0200;
        params_i.inertia_comp_enable_param = 8'h02;
        set_term(8'h1f);
        chk("ponly", 2'h0, {p_only_o, inertia_comp_o});
        chk("tset2", 2'h3, {torque_limit_set2_o, speed_fb_invert_o});
        params_i.inertia_comp_enable_param = 8'h01;
        do_reset();
    endtask : t_misc

    task automatic t_role();
        map(0, FN_ROLE_SLAVE);
        set_term(8'h00);
        chk("master", 2'h2, {role_o.peer_tx_enable, role_o.peer_rx_enable});
        chk("mode", 2'h0, {role_o.slave_mode, role_o.speed_ctrl_disable});
        set_term(8'h01);
        chk("slave", 2'h1, {role_o.peer_tx_enable, role_o.peer_rx_enable});
        chk("mode", 2'h3, {role_o.slave_mode, role_o.speed_ctrl_disable});
        chk("torque", 2'h1, {1'b0, role_o.torque_from_peer});
        chk("peer", 2'h3, {role_o.peer_bus_ready, role_o.torque_is_tx_word0});
        params_i.baud_code_param = 8'h09;
        set_term(8'h01);
        chk("baud", 2'h0, {role_o.peer_tx_enable, role_o.peer_rx_enable});
        chk("peer", 2'h1, {role_o.peer_bus_ready, role_o.torque_is_tx_word0});
    endtask : t_role

    initial begin
        params_i = '0;
        params_i.ramp_set_select_param = 2'h1;
        params_i.tech_droop_param = 1'b1;
        params_i.inertia_comp_enable_param = 8'h01;
        params_i.p_only_speed_threshold = 16'h0100;
        params_i.torque_limit_speed_threshold = 16'h0100;
        params_i.slave_torque_source_param = PEER_TORQUE_SOURCE;
        params_i.bus_protocol_select_param = PEER_PROTOCOL_CODE;
        params_i.baud_code_param = PEER_BAUD_CODE;
        params_i.peer_tx_word0_param = PEER_TX_WORD0_CODE;
        repeat (20) @(negedge sys_clk_i);
        resetn_i = 1;
        repeat (2) @(negedge sys_clk_i);
        t_reset();
        t_pot();
        t_ramp();
        t_pset();
        t_droop();
        t_misc();
        t_role();
        test_done();
    end
endmodule : test_drive_binary_input_function_select
`default_nettype wire
